// ### rtl/cap_mode_regs.sv
// Store for the base and three extended mode registers with registered read data.
`timescale 1ns/1ns
module cap_mode_regs
   import cap_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rstn,
   cap_mr_if.mem     mr
);
   cap_mr_state_t st_reg;
   cap_mr_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (mr.wr_en) begin
         st_next.mr[mr.wr_sel] = mr.wr_data;
      end
      // Read data reflects the store as it stood before this edge.
      st_next.rdata = st_reg.mr[mr.rd_sel];
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_reg <= '{mr: {MR_NUM{MR_RESET}}, rdata: MR_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   assign mr.rd_data = st_reg.rdata;
endmodule

// ### rtl/cap_mr_if.sv
// Carrier between the command decoder and the mode register store.
`timescale 1ns/1ns
interface cap_mr_if;
   import cap_pkg::*;
   logic                wr_en;
   logic [1:0]          wr_sel;
   logic [ADDR_W-1:0]   wr_data;
   logic [1:0]          rd_sel;
   logic [ADDR_W-1:0]   rd_data;
   modport ctl (output wr_en, output wr_sel, output wr_data, output rd_sel, input rd_data);
   modport mem (input wr_en, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface

// ### rtl/cap_pkg.sv
// Shared constants and types for the command and address input port.
package cap_pkg;

   localparam int ADDR_W      = 14;
   localparam int ROW_W_X16   = 13;
   localparam int COL_W       = 10;
   localparam int BANK_W      = 2;
   localparam int NUM_BANKS   = 4;
   localparam int DQ_W        = 16;
   localparam int LANES       = 2;
   localparam int MR_NUM      = 4;

   // Field positions on the address bus.
   localparam int AP_BIT      = 10;
   localparam int ROW_TOP_BIT = 13;

   // Mode register selections on the bank bits.
   localparam logic [1:0] MR_BASE = 2'h0;
   localparam logic [1:0] MR_EXT1 = 2'h1;
   localparam logic [1:0] MR_EXT2 = 2'h2;
   localparam logic [1:0] MR_EXT3 = 2'h3;

   // Bit of extended register one that turns the delay-locked loop off when set.
   localparam int DLL_OFF_BIT = 0;

   // Reset values, and the mask that selects all banks for precharge.
   localparam logic [ADDR_W-1:0] MR_RESET    = 14'h0000;
   localparam logic [3:0]        ALL_BANKS   = 4'hF;
   localparam logic [3:0]        NO_BANKS    = 4'h0;

   // Command code {ras_n, cas_n, we_n} while chip select is low.
   typedef enum logic [2:0] {
      CAP_CMD_LOAD_MODE = 3'h0,
      CAP_CMD_REFRESH   = 3'h1,
      CAP_CMD_PRECHARGE = 3'h2,
      CAP_CMD_ACTIVATE  = 3'h3,
      CAP_CMD_WRITE     = 3'h4,
      CAP_CMD_READ      = 3'h5,
      CAP_CMD_RESERVED  = 3'h6,
      CAP_CMD_NOP       = 3'h7
   } cap_cmd_t;

   typedef struct packed {
      logic                  x16_meta;
      logic                  x16_sync;
      logic                  cmd_v;
      cap_cmd_t              cmd;
      logic [BANK_W-1:0]     bank;
      logic [NUM_BANKS-1:0]  pre_banks;
      logic [ADDR_W-1:0]     row;
      logic [COL_W-1:0]      col;
      logic                  auto_pre;
      logic [1:0]            mr_sel;
      logic [ADDR_W-1:0]     opcode;
      logic                  mr_wr;
      logic                  wr_v;
      logic [DQ_W-1:0]       wr_dq;
      logic [LANES-1:0]      wr_be;
      logic                  rd_v;
      logic [DQ_W-1:0]       rd_dq;
      logic                  rd_dqs;
   } cap_state_t;

   typedef struct packed {
      logic [MR_NUM-1:0][ADDR_W-1:0] mr;
      logic [ADDR_W-1:0]             rdata;
   } cap_mr_state_t;

endpackage

// ### rtl/cap_port.sv
// Command and address input port of a four-bank double data rate memory device.
`timescale 1ns/1ns
module cap_port
   import cap_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   input  wire logic                 x16_strap,
   input  wire logic                 cs_n,
   input  wire logic                 ras_n,
   input  wire logic                 cas_n,
   input  wire logic                 we_n,
   input  wire logic [BANK_W-1:0]    ba,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic                 wr_beat,
   input  wire logic [DQ_W-1:0]      wr_dq_in,
   input  wire logic [LANES-1:0]     wr_dm,
   input  wire logic                 rd_beat,
   input  wire logic [DQ_W-1:0]      rd_dq_in,
   output logic                      cmd_valid,
   output cap_cmd_t                  cmd,
   output logic [BANK_W-1:0]         bank,
   output logic [NUM_BANKS-1:0]      pre_banks,
   output logic [ADDR_W-1:0]         row,
   output logic [COL_W-1:0]          col,
   output logic                      auto_pre,
   output logic                      mr_write,
   output logic [1:0]                mr_sel,
   output logic [ADDR_W-1:0]         mr_opcode,
   output logic                      dll_enabled,
   output logic                      wr_valid,
   output logic [DQ_W-1:0]           wr_dq,
   output logic [LANES-1:0]          wr_be,
   output logic                      rd_valid,
   output logic [DQ_W-1:0]           rd_dq,
   output logic                      rd_dqs
);
   cap_state_t st_reg;
   cap_state_t st_next;
   cap_mr_if   mr_bus ();
   cap_cmd_t   dec_cmd;
   logic       take;

   cap_mode_regs u_mode_regs (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .mr      (mr_bus.mem)
   );

   assign dec_cmd = cap_cmd_t'({ras_n, cas_n, we_n});
   assign take    = !cs_n && (dec_cmd != CAP_CMD_NOP);

   always_comb begin
      st_next          = st_reg;
      // The strap is a board level, so it passes two flops before use.
      st_next.x16_meta = x16_strap;
      st_next.x16_sync = st_reg.x16_meta;
      st_next.cmd_v    = take;
      st_next.mr_wr    = 1'b0;
      if (take) begin
         st_next.cmd    = dec_cmd;
         st_next.bank   = ba;
         st_next.mr_sel = ba;
         case (dec_cmd)
            CAP_CMD_ACTIVATE: begin
               st_next.row = addr;
               if (st_reg.x16_sync) begin
                  st_next.row[ROW_TOP_BIT] = 1'b0;
               end
            end
            CAP_CMD_READ, CAP_CMD_WRITE: begin
               st_next.col      = addr[COL_W-1:0];
               st_next.auto_pre = addr[AP_BIT];
            end
            CAP_CMD_PRECHARGE: begin
               if (addr[AP_BIT]) begin
                  st_next.pre_banks = ALL_BANKS;
               end else begin
                  st_next.pre_banks = NUM_BANKS'(1) << ba;
               end
            end
            CAP_CMD_LOAD_MODE: begin
               st_next.mr_wr  = 1'b1;
               st_next.opcode = addr;
            end
            default: begin
               st_next.pre_banks = st_reg.pre_banks;
            end
         endcase
      end
      // Write beats: a masked lane is dropped, and narrow parts use only the low mask.
      st_next.wr_v  = wr_beat;
      st_next.wr_dq = wr_dq_in;
      st_next.wr_be = ~wr_dm;
      if (!st_reg.x16_sync) begin
         st_next.wr_be[1] = 1'b0;
      end
      if (!wr_beat) begin
         st_next.wr_be = '0;
      end
      // Read beats leave on the clock edge; the strobe toggles once per beat.
      st_next.rd_v  = rd_beat;
      st_next.rd_dq = rd_dq_in;
      if (rd_beat) begin
         st_next.rd_dqs = ~st_reg.rd_dqs;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_reg           <= '0;
         st_reg.cmd       <= CAP_CMD_NOP;
         st_reg.pre_banks <= NO_BANKS;
      end else begin
         st_reg <= st_next;
      end
   end

   assign mr_bus.wr_en   = st_reg.mr_wr;
   assign mr_bus.wr_sel  = st_reg.mr_sel;
   assign mr_bus.wr_data = st_reg.opcode;
   assign mr_bus.rd_sel  = MR_EXT1;

   // The loop state is read back from the store, so it trails a mode write by two edges.
   assign dll_enabled = !mr_bus.rd_data[DLL_OFF_BIT];
   assign cmd_valid   = st_reg.cmd_v;
   assign cmd         = st_reg.cmd;
   assign bank        = st_reg.bank;
   assign pre_banks   = st_reg.pre_banks;
   assign row         = st_reg.row;
   assign col         = st_reg.col;
   assign auto_pre    = st_reg.auto_pre;
   assign mr_write    = st_reg.mr_wr;
   assign mr_sel      = st_reg.mr_sel;
   assign mr_opcode   = st_reg.opcode;
   assign wr_valid    = st_reg.wr_v;
   assign wr_dq       = st_reg.wr_dq;
   assign wr_be       = st_reg.wr_be;
   assign rd_valid    = st_reg.rd_v;
   assign rd_dq       = st_reg.rd_dq;
   assign rd_dqs      = st_reg.rd_dqs;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_cs_high_ignored;
      cs_n |=> !cmd_valid;
   endproperty
   a_cs_high_ignored: assert property (p_cs_high_ignored) else $error("command taken with chip select high");

   property p_cmd_decode;
      !cs_n && !(ras_n && cas_n && we_n) |=> cmd_valid && cmd == cap_cmd_t'($past({ras_n, cas_n, we_n}));
   endproperty
   a_cmd_decode: assert property (p_cmd_decode) else $error("command code mismatch");

   property p_row_addr;
      !cs_n && {ras_n, cas_n, we_n} == CAP_CMD_ACTIVATE && st_reg.x16_sync && $stable(st_reg.x16_sync)
         |=> row == {1'b0, $past(addr[ROW_TOP_BIT-1:0])} && bank == $past(ba);
   endproperty
   a_row_addr: assert property (p_row_addr) else $error("row or bank not captured");

   property p_auto_pre;
      !cs_n && ras_n && !cas_n |=> auto_pre == $past(addr[AP_BIT]) && col == $past(addr[COL_W-1:0]);
   endproperty
   a_auto_pre: assert property (p_auto_pre) else $error("auto precharge flag or column wrong");

   property p_pre_all;
      !cs_n && {ras_n, cas_n, we_n} == CAP_CMD_PRECHARGE && addr[AP_BIT] |=> pre_banks == ALL_BANKS;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all did not select all banks");

   property p_pre_one;
      !cs_n && {ras_n, cas_n, we_n} == CAP_CMD_PRECHARGE && !addr[AP_BIT]
         |=> $onehot(pre_banks) && pre_banks[$past(ba)];
   endproperty
   a_pre_one: assert property (p_pre_one) else $error("single bank precharge wrong bank");

   property p_load_mode;
      !cs_n && {ras_n, cas_n, we_n} == CAP_CMD_LOAD_MODE
         |=> mr_write && mr_sel == $past(ba) && mr_opcode == $past(addr);
   endproperty
   a_load_mode: assert property (p_load_mode) else $error("mode register write not formed");

   property p_dll_follow;
      mr_write && mr_sel == MR_EXT1 |-> ##2 dll_enabled == !$past(mr_opcode[DLL_OFF_BIT], 2);
   endproperty
   a_dll_follow: assert property (p_dll_follow) else $error("loop enable does not follow mode write");

   property p_mask_drop;
      wr_beat && wr_dm[0] |=> wr_valid && !wr_be[0];
   endproperty
   a_mask_drop: assert property (p_mask_drop) else $error("masked beat not discarded");

   // The lane enables are registered, so they follow the synchronised strap one edge later.
   property p_upper_lane;
      !st_reg.x16_sync |=> !wr_be[1];
   endproperty
   a_upper_lane: assert property (p_upper_lane) else $error("upper lane enabled on narrow part");

   property p_read_strobe;
      rd_beat |=> rd_valid && rd_dqs != $past(rd_dqs) && rd_dq == $past(rd_dq_in);
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read beat not launched with strobe");

   // Fields and the valid pulse are loaded at the same edge, so no pulse means no field moved.
   property p_sample_edge;
      !cmd_valid |-> $stable(row) && $stable(col);
   endproperty
   a_sample_edge: assert property (p_sample_edge) else $error("captured address moved without a command");
endmodule

// ### test/cap_ctl_model.sv
// Behavioural memory controller that drives the command and address inputs of the port.
`timescale 1ns/1ns
module cap_ctl_model
   import cap_pkg::*;
(
   output logic              cs_n,
   output logic              ras_n,
   output logic              cas_n,
   output logic              we_n,
   output logic [BANK_W-1:0] ba,
   output logic [ADDR_W-1:0] addr
);
   // Refresh rate against case temperature is not modelled: there is no temperature input.
   logic dll_off_ok;
   initial begin
      dll_off_ok = 1'b0;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      ba = 2'h0;
      addr = 14'h0000;
   end
   // Callers enter at the falling edge, so each level stands a whole cycle around the rising edge.
   task automatic put(input logic sel_n, input cap_cmd_t code, input logic [BANK_W-1:0] b,
                      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] op;
      op = a;
      if (!sel_n && code == CAP_CMD_LOAD_MODE && b == MR_EXT1 && !dll_off_ok) begin
         op[DLL_OFF_BIT] = 1'b0;
      end
      cs_n = sel_n;
      {ras_n, cas_n, we_n} = code;
      // A deselected device sees stale lines turned over, so an old value cannot pass for a new one.
      ba = sel_n ? ~ba : b;
      addr = sel_n ? ~addr : op;
   endtask
endmodule

// ### test/cap_port_tb.sv
// Self-checking random bench for the command and address input port.
`timescale 1ns/1ns
module cap_port_tb;
   import cap_pkg::*;
   logic sys_clk, rstn, x16_strap, cs_n, ras_n, cas_n, we_n, wr_beat, rd_beat;
   logic [1:0] ba, wr_dm;
   logic [13:0] addr;
   logic [15:0] wr_dq_in, rd_dq_in;
   logic cmd_valid, auto_pre, mr_write, dll_enabled, wr_valid, rd_valid, rd_dqs;
   cap_cmd_t cmd, e_cmd;
   logic [1:0] bank, mr_sel, wr_be, e_bank, e_sel, e_wbe;
   logic [3:0] pre_banks, e_pre;
   logic [13:0] row, mr_opcode, e_row, e_op;
   logic [9:0] col, e_col;
   logic [15:0] wr_dq, rd_dq, e_wdq, e_rdq;
   logic e_v, e_ap, e_mrw, e_wv, e_rv, e_dqs, mr1;
   logic [2:0] h;
   logic [31:0] seed, r, q;
   int bad_count, n_compared, i;
   cap_ctl_model cap_ctl_model_i (.cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
   cap_port cap_port_i (.sys_clk(sys_clk), .rstn(rstn), .x16_strap(x16_strap), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .wr_beat(wr_beat), .wr_dq_in(wr_dq_in), .wr_dm(wr_dm),
      .rd_beat(rd_beat), .rd_dq_in(rd_dq_in), .cmd_valid(cmd_valid), .cmd(cmd), .bank(bank),
      .pre_banks(pre_banks), .row(row), .col(col), .auto_pre(auto_pre), .mr_write(mr_write), .mr_sel(mr_sel),
      .mr_opcode(mr_opcode), .dll_enabled(dll_enabled), .wr_valid(wr_valid), .wr_dq(wr_dq), .wr_be(wr_be),
      .rd_valid(rd_valid), .rd_dq(rd_dq), .rd_dqs(rd_dqs));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic check();
      chk(cmd_valid, e_v);
      chk(cmd, e_cmd);
      chk(bank, e_bank);
      chk(pre_banks, e_pre);
      chk(row, e_row);
      chk(col, e_col);
      chk(auto_pre, e_ap);
      chk(mr_write, e_mrw);
      chk(mr_sel, e_sel);
      chk(mr_opcode, e_op);
      chk(dll_enabled, !h[2]);
      chk(wr_valid, e_wv);
      if (e_wv) chk(wr_dq, e_wdq);
      chk(wr_be, e_wbe);
      chk(rd_valid, e_rv);
      chk(rd_dq, e_rdq);
      chk(rd_dqs, e_dqs);
   endtask
   // One bus cycle: check what the previous edge produced, drive new levels, predict the next edge.
   task automatic cyc(input logic s, input cap_cmd_t c, input logic [1:0] b, input logic [13:0] a,
                      input logic wb, input logic [1:0] dm, input logic [15:0] d, input logic rb);
      @(negedge sys_clk);
      check();
      cap_ctl_model_i.put(s, c, b, a);
      wr_beat = wb;
      wr_dm = dm;
      wr_dq_in = d;
      rd_beat = rb;
      rd_dq_in = ~d;
      e_v = !cs_n && c != CAP_CMD_NOP;
      e_mrw = 1'b0;
      if (e_v) begin
         e_cmd = c;
         // Every taken command loads the bank and mode select outputs from the bank bits.
         e_bank = ba;
         e_sel = ba;
         case (c)
            CAP_CMD_ACTIVATE: begin
               e_row = {addr[13] & ~x16_strap, addr[12:0]};
            end
            CAP_CMD_READ, CAP_CMD_WRITE: begin
               e_col = addr[9:0];
               e_ap = addr[AP_BIT];
            end
            CAP_CMD_PRECHARGE: begin
               e_pre = addr[AP_BIT] ? ALL_BANKS : 4'h1 << ba;
            end
            CAP_CMD_LOAD_MODE: begin
               e_mrw = 1'b1;
               e_op = addr;
               if (ba == MR_EXT1) mr1 = addr[DLL_OFF_BIT];
            end
            default: ;
         endcase
      end
      h = {h[1:0], mr1};
      e_wv = wb;
      e_wdq = d;
      e_wbe = wb ? ~dm & {x16_strap, 1'b1} : 2'h0;
      e_rv = rb;
      // Read data follow the core lines every cycle; only the valid and the strobe mark a beat.
      e_rdq = ~d;
      if (rb) e_dqs = ~e_dqs;
   endtask
   task automatic rand_run(input int n);
      for (int k = 0; k < n; k++) begin
         r = xs();
         q = xs();
         cyc(r[0] & r[1], cap_cmd_t'(r[4:2]), r[6:5], r[20:7], r[21], r[23:22], q[15:0], r[24]);
      end
   endtask
   task automatic end_sim();
      $display("compared=%0d bad=%0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   initial begin
      {rstn, wr_beat, rd_beat, wr_dm, wr_dq_in, rd_dq_in} = '0;
      x16_strap = 1'b1;
      seed = 32'hA20D;
      {e_v, e_ap, e_mrw, e_wv, e_rv, e_dqs, mr1, h, e_sel, e_bank, e_wbe, e_pre, e_row, e_op, e_col} = '0;
      {e_wdq, e_rdq} = '0;
      e_cmd = CAP_CMD_NOP;
      bad_count = 0;
      n_compared = 0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) rstn = 1'b1;
      cyc(1'b0, CAP_CMD_PRECHARGE, 2'h2, 14'h0000, 1'b1, 2'h2, 16'hA55A, 1'b1);
      cyc(1'b0, CAP_CMD_PRECHARGE, 2'h1, 14'h0400, 1'b1, 2'h1, 16'h5AA5, 1'b1);
      for (i = 0; i < 8; i++) cyc(1'b0, cap_cmd_t'(i), i[1:0], 14'h3FFF, 1'b0, 2'h0, 16'h0000, 1'b0);
      for (i = 0; i < 4; i++) cyc(1'b0, CAP_CMD_LOAD_MODE, i[1:0], 14'h2AAA ^ 14'(i), 1'b0, 2'h0, 16'h0000, 1'b0);
      $display("test done: directed commands");
      cap_ctl_model_i.dll_off_ok = 1'b1;
      cyc(1'b0, CAP_CMD_LOAD_MODE, MR_EXT1, 14'h0001, 1'b0, 2'h0, 16'h0000, 1'b0);
      repeat (4) cyc(1'b1, CAP_CMD_NOP, 2'h0, 14'h0000, 1'b0, 2'h0, 16'h0000, 1'b0);
      cyc(1'b0, CAP_CMD_LOAD_MODE, MR_EXT1, 14'h0000, 1'b0, 2'h0, 16'h0000, 1'b0);
      cap_ctl_model_i.dll_off_ok = 1'b0;
      $display("test done: loop switch");
      rand_run(300);
      $display("test done: random wide part");
      // The strap passes two flops, so only idle cycles may run while it settles.
      x16_strap = 1'b0;
      repeat (4) cyc(1'b1, CAP_CMD_NOP, 2'h0, 14'h0000, 1'b0, 2'h0, 16'h0000, 1'b0);
      rand_run(300);
      // One idle cycle more, so that the last random command is checked as well.
      cyc(1'b1, CAP_CMD_NOP, 2'h0, 14'h0000, 1'b0, 2'h0, 16'h0000, 1'b0);
      $display("test done: random narrow part");
      end_sim();
   end
endmodule
